//--- src/anreg_bank.sv
// Purpose: management register bank of the link negotiation function
// Assumes: register port and arbitration signals share clk
// Notes: read data is registered; read side effects act in the read cycle
`timescale 1ns/1ps
module anreg_bank #(
    parameter logic AN_CAPABLE = 1'b1,
    parameter logic NP_CAPABLE = 1'b1,
    parameter logic [4:0] TECH_ABILITY = anreg_pkg::TECH_ABILITY_DEFAULT,
    parameter int NUM_DET = 3
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic restart_begun,
    input wire logic an_success,
    input wire logic link_ok,
    input wire logic res_speed,
    input wire logic res_duplex,
    input wire logic lp_word_valid,
    input wire logic lp_word_base,
    input wire logic [15:0] lp_word,
    input wire logic lp_an_detect,
    input wire logic wait_timer_done,
    input wire logic [NUM_DET-1:0] det_ready,
    input wire logic np_consumed,
    output logic an_enable,
    output logic an_restart,
    output logic link_speed,
    output logic link_duplex,
    output logic [15:0] adv_ability,
    output logic [15:0] np_tx_word,
    output logic np_able,
    output logic lp_np_able,
    output logic next_page_loaded
);
    logic ctl_speed_q, ctl_speed_d;
    logic ctl_an_en_q, ctl_an_en_d;
    logic ctl_duplex_q, ctl_duplex_d;
    logic restart_q, restart_d;
    logic done_q, done_d;
    logic rfault_q, rfault_d;
    logic [15:0] adv_q, adv_d;
    logic [15:0] lp_q, lp_d;
    logic lp_an_q, lp_an_d;
    logic page_rx_q, page_rx_d;
    logic lp_np_q, lp_np_d;
    logic pdf_q, pdf_d;
    logic [15:0] np_q, np_d;
    logic np_loaded_q, np_loaded_d;
    logic [15:0] rdata_q, rdata_d;
    logic rvalid_q;
    logic speed_q, speed_d;
    logic duplex_q, duplex_d;

    // address decode
    wire sel_ctl = (reg_addr == anreg_pkg::OFS_CONTROL);
    wire sel_sts = (reg_addr == anreg_pkg::OFS_STATUS);
    wire sel_adv = (reg_addr == anreg_pkg::OFS_ADVERT);
    wire sel_lp = (reg_addr == anreg_pkg::OFS_PARTNER);
    wire sel_exp = (reg_addr == anreg_pkg::OFS_EXPAND);
    wire sel_np = (reg_addr == anreg_pkg::OFS_NP_TX) && NP_CAPABLE;
    wire wr_ctl = reg_wr && sel_ctl;
    wire wr_adv = reg_wr && sel_adv;
    wire wr_np = reg_wr && sel_np;
    wire rd_sts = reg_rd && sel_sts;
    wire rd_exp = reg_rd && sel_exp;

    // a single detector must be ready; none or several is a fault
    wire [NUM_DET-1:0] det_less_one = det_ready - {{(NUM_DET-1){1'b0}}, 1'b1};
    wire det_none = (det_ready == '0);
    wire det_many = ((det_ready & det_less_one) != '0);
    wire pd_fault_evt = wait_timer_done && (det_none || det_many);

    wire base_rx = lp_word_valid && lp_word_base;
    wire rf_evt = base_rx && lp_word[anreg_pkg::ADV_RF];
    wire an_live = ctl_an_en_q && AN_CAPABLE;

    // register images
    wire [15:0] ctl_img = {2'b00, ctl_speed_q, ctl_an_en_q, 2'b00, restart_q,
                           ctl_duplex_q, 8'h00};
    wire [15:0] sts_img = {TECH_ABILITY, 5'h00, done_q && an_live, rfault_q,
                           AN_CAPABLE, link_ok, 1'b0, 1'b1};
    wire [15:0] exp_img = {11'h000, pdf_q, lp_np_q, NP_CAPABLE, page_rx_q,
                           lp_an_q};
    wire [15:0] rd_mux =
        sel_ctl ? ctl_img :
        sel_sts ? sts_img :
        sel_adv ? adv_q :
        sel_lp ? lp_q :
        sel_exp ? exp_img :
        sel_np ? np_q : anreg_pkg::DATA_ZERO;

    // control register; partner and expansion have no write path
    always_comb begin
        ctl_speed_d = wr_ctl ? reg_wdata[anreg_pkg::CTL_SPEED] : ctl_speed_q;
        ctl_an_en_d = wr_ctl ? reg_wdata[anreg_pkg::CTL_AN_EN] : ctl_an_en_q;
        ctl_duplex_d = wr_ctl ? reg_wdata[anreg_pkg::CTL_DUPLEX] : ctl_duplex_q;
        // only a one sets; writing zero leaves it alone
        if (wr_ctl && reg_wdata[anreg_pkg::CTL_RESTART] && AN_CAPABLE) begin
            restart_d = 1'b1;
        end else if (restart_begun) begin
            restart_d = 1'b0;
        end else begin
            restart_d = restart_q;
        end
    end

    // negotiation complete
    always_comb begin
        if (an_success && an_live) begin
            done_d = 1'b1;
        end else if (!an_live || restart_q) begin
            done_d = 1'b0;
        end else begin
            done_d = done_q;
        end
    end

    // latched and clear-on-read bits: event beats the read
    assign rfault_d = rf_evt ? 1'b1 : (rd_sts ? 1'b0 : rfault_q);
    assign page_rx_d = lp_word_valid ? 1'b1 : (rd_exp ? 1'b0 : page_rx_q);
    assign pdf_d = pd_fault_evt ? 1'b1 : (rd_exp ? 1'b0 : pdf_q);

    // partner code word, base or next page alike
    assign lp_d = lp_word_valid ? lp_word : lp_q;
    assign lp_an_d = lp_an_detect ? 1'b1 : (restart_begun ? 1'b0 : lp_an_q);
    assign lp_np_d = base_rx ? lp_word[anreg_pkg::ADV_NP] : lp_np_q;

    // ack is owned by arbitration, so software cannot set it
    always_comb begin
        adv_d = adv_q;
        if (wr_adv) begin
            adv_d = reg_wdata;
            adv_d[anreg_pkg::ADV_ACK] = 1'b0;
        end
    end

    assign np_d = wr_np ? reg_wdata : np_q;
    assign np_loaded_d = wr_np ? 1'b1 : (np_consumed ? 1'b0 : np_loaded_q);

    // negotiated result wins whenever negotiation is enabled and AN_CAPABLE is set
    assign speed_d = an_live ? res_speed : ctl_speed_q;
    assign duplex_d = an_live ? res_duplex : ctl_duplex_q;

    assign rdata_d = reg_rd ? rd_mux : rdata_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctl_speed_q <= 1'b1;
            ctl_an_en_q <= 1'b1;
            ctl_duplex_q <= 1'b0;
            restart_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            ctl_speed_q <= ctl_speed_d;
            ctl_an_en_q <= ctl_an_en_d;
            ctl_duplex_q <= ctl_duplex_d;
            restart_q <= restart_d;
            done_q <= done_d;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rfault_q <= 1'b0;
            page_rx_q <= 1'b0;
            pdf_q <= 1'b0;
            lp_q <= anreg_pkg::DATA_ZERO;
            lp_an_q <= 1'b0;
            lp_np_q <= 1'b0;
        end else begin
            rfault_q <= rfault_d;
            page_rx_q <= page_rx_d;
            pdf_q <= pdf_d;
            lp_q <= lp_d;
            lp_an_q <= lp_an_d;
            lp_np_q <= lp_np_d;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            // ability field mirrors status bits 15:11
            adv_q <= {2'b00, 1'b0, 3'h0, TECH_ABILITY, anreg_pkg::SELECTOR_CODE};
            np_q <= anreg_pkg::NP_TX_RESET;
            np_loaded_q <= 1'b0;
        end else begin
            adv_q <= adv_d;
            np_q <= np_d;
            np_loaded_q <= np_loaded_d;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= anreg_pkg::DATA_ZERO;
            rvalid_q <= 1'b0;
            speed_q <= 1'b0;
            duplex_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= reg_rd;
            speed_q <= speed_d;
            duplex_q <= duplex_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign an_enable = ctl_an_en_q;
    assign an_restart = restart_q;
    assign link_speed = speed_q;
    assign link_duplex = duplex_q;
    assign adv_ability = adv_q;
    assign np_tx_word = np_q;
    assign np_able = NP_CAPABLE;
    assign lp_np_able = lp_np_q;
    assign next_page_loaded = np_loaded_q;

    property p_restart_set;
        @(posedge clk) disable iff (!arst_n)
        wr_ctl && reg_wdata[anreg_pkg::CTL_RESTART] && AN_CAPABLE |=> an_restart;
    endproperty
    a_restart_set: assert property (p_restart_set)
        else $error("restart bit not set by write of one");

    property p_restart_holds;
        @(posedge clk) disable iff (!arst_n)
        an_restart && !restart_begun |=> an_restart;
    endproperty
    a_restart_holds: assert property (p_restart_holds)
        else $error("restart bit dropped before negotiation began");

    property p_restart_zero_write;
        @(posedge clk) disable iff (!arst_n)
        wr_ctl && !reg_wdata[anreg_pkg::CTL_RESTART] && !restart_begun
            |=> an_restart == $past(an_restart);
    endproperty
    a_restart_zero_write: assert property (p_restart_zero_write)
        else $error("writing zero changed the restart bit");

    property p_done_off;
        @(posedge clk) disable iff (!arst_n)
        !an_live |=> !done_q;
    endproperty
    a_done_off: assert property (p_done_off)
        else $error("complete bit set while negotiation disabled");

    property p_done_set;
        @(posedge clk) disable iff (!arst_n)
        an_success && an_live && !wr_ctl |=> sts_img[anreg_pkg::STS_AN_DONE];
    endproperty
    a_done_set: assert property (p_done_set)
        else $error("complete bit not set after success");

    property p_rfault_latch;
        @(posedge clk) disable iff (!arst_n)
        rf_evt ##1 !rd_sts |=> rfault_q;
    endproperty
    a_rfault_latch: assert property (p_rfault_latch)
        else $error("remote fault not held until status read");

    property p_read_clear_race;
        @(posedge clk) disable iff (!arst_n)
        rd_exp && lp_word_valid |=> page_rx_q;
    endproperty
    a_read_clear_race: assert property (p_read_clear_race)
        else $error("page event lost on same-cycle read");

    property p_exp_clear;
        @(posedge clk) disable iff (!arst_n)
        rd_exp && !lp_word_valid && !pd_fault_evt |=> !page_rx_q && !pdf_q;
    endproperty
    a_exp_clear: assert property (p_exp_clear)
        else $error("expansion read did not clear sticky bits");

    property p_pd_fault;
        @(posedge clk) disable iff (!arst_n)
        wait_timer_done && $countones(det_ready) != 1 |=> pdf_q;
    endproperty
    a_pd_fault: assert property (p_pd_fault)
        else $error("no fault with zero or several detectors ready");

    property p_lp_store;
        @(posedge clk) disable iff (!arst_n)
        lp_word_valid |=> lp_q == $past(lp_word) && page_rx_q;
    endproperty
    a_lp_store: assert property (p_lp_store)
        else $error("partner word not stored");

    property p_ro_write;
        @(posedge clk) disable iff (!arst_n)
        reg_wr && sel_lp && !lp_word_valid |=> $stable(lp_q);
    endproperty
    a_ro_write: assert property (p_ro_write)
        else $error("write changed partner register");

    property p_np_loaded;
        @(posedge clk) disable iff (!arst_n)
        wr_np |=> next_page_loaded && np_tx_word == $past(reg_wdata);
    endproperty
    a_np_loaded: assert property (p_np_loaded)
        else $error("next page write did not raise loaded flag");

    property p_override;
        @(posedge clk) disable iff (!arst_n)
        an_live && !wr_ctl |=> link_speed == $past(res_speed)
            && link_duplex == $past(res_duplex);
    endproperty
    a_override: assert property (p_override)
        else $error("manual setting used while negotiating");

    property p_rd_answer;
        @(posedge clk) disable iff (!arst_n)
        reg_rd |=> reg_rvalid ##1 !reg_rvalid || $past(reg_rd);
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read answer not one cycle later");

    property p_rfault_hold;
        @(posedge clk) disable iff (!arst_n)
        rfault_q && !rd_sts |=> rfault_q;
    endproperty
    a_rfault_hold: assert property (p_rfault_hold)
        else $error("remote fault dropped without status read");

    property p_restart_clear;
        @(posedge clk) disable iff (!arst_n)
        restart_begun && !(wr_ctl && reg_wdata[anreg_pkg::CTL_RESTART]) |=> !an_restart;
    endproperty
    a_restart_clear: assert property (p_restart_clear)
        else $error("restart bit not cleared once negotiation began");

    property p_lp_able;
        @(posedge clk) disable iff (!arst_n)
        lp_an_detect |=> lp_an_q;
    endproperty
    a_lp_able: assert property (p_lp_able)
        else $error("partner able bit not set on detection");

    property p_np_consume;
        @(posedge clk) disable iff (!arst_n)
        np_consumed && !wr_np |=> !next_page_loaded;
    endproperty
    a_np_consume: assert property (p_np_consume)
        else $error("loaded flag kept after next page taken");
endmodule : anreg_bank

//--- src/anreg_pkg.sv
// Purpose: constants for the negotiation management register bank
// Assumes: 5-bit management register addresses, 16-bit registers
// Notes: field positions are bit indices within a 16-bit register
package anreg_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;

    localparam logic [4:0] OFS_CONTROL = 5'h00;
    localparam logic [4:0] OFS_STATUS = 5'h01;
    localparam logic [4:0] OFS_ADVERT = 5'h04;
    localparam logic [4:0] OFS_PARTNER = 5'h05;
    localparam logic [4:0] OFS_EXPAND = 5'h06;
    localparam logic [4:0] OFS_NP_TX = 5'h07;

    // control fields
    localparam int CTL_SPEED = 13;
    localparam int CTL_AN_EN = 12;
    localparam int CTL_RESTART = 9;
    localparam int CTL_DUPLEX = 8;

    // status fields
    localparam int STS_ABIL_LO = 11;
    localparam int STS_AN_DONE = 5;
    localparam int STS_RFAULT = 4;
    localparam int STS_AN_ABLE = 3;
    localparam int STS_LINK = 2;
    localparam int STS_EXT = 0;

    // advertisement / code word fields
    localparam int ADV_NP = 15;
    localparam int ADV_ACK = 14;
    localparam int ADV_RF = 13;
    localparam int ADV_TECH_LO = 5;
    localparam int ADV_SEL_LO = 0;
    localparam logic [4:0] SELECTOR_CODE = 5'h01;

    // expansion fields
    localparam int EXP_LP_AN_ABLE = 0;
    localparam int EXP_PAGE_RX = 1;
    localparam int EXP_NP_ABLE = 2;
    localparam int EXP_LP_NP_ABLE = 3;
    localparam int EXP_PD_FAULT = 4;

    // reset values
    localparam logic [15:0] NP_TX_RESET = 16'h2001;
    localparam logic [15:0] DATA_ZERO = 16'h0000;
    localparam logic [4:0] TECH_ABILITY_DEFAULT = 5'h1F;
endpackage : anreg_pkg

//--- testbench/anreg_sme_model.sv
// Purpose: station management model issuing register reads and writes
// Assumes: strobes taken on rising clk, read answer one cycle later
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module anreg_sme_model (
    input wire logic clk,
    output logic [4:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid
);
    int n_late = 0;
    initial begin
        reg_addr = 5'h1F;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'hFFFF;
    end
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        // stale values would hide a decode that samples too late
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        int i;
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++) @(negedge clk);
        if (reg_rvalid !== 1'b1 || i != 0) n_late++;
        d = reg_rdata;
    endtask : rd
endmodule : anreg_sme_model

//--- testbench/anreg_bank_tb.sv
// Purpose: self-checking bench for the negotiation register bank
// Assumes: all register cycles go through the management model
// Notes: expected images are rebuilt from shadow state kept here
`timescale 1ns/1ps
module anreg_bank_tb;
    localparam logic [4:0] TECH = 5'h15;
    logic clk = 1'b0, arst_n = 1'b0;
    logic [4:0] reg_addr;
    logic reg_wr, reg_rd, reg_rvalid;
    logic [15:0] reg_wdata, reg_rdata, lp_word = 16'h0000, adv_ability, np_tx_word;
    logic restart_begun = 0, an_success = 0, link_ok = 0, res_speed = 0, res_duplex = 0;
    logic lp_word_valid = 0, lp_word_base = 0, lp_an_detect = 0, wait_timer_done = 0;
    logic [2:0] det_ready = 3'h0;
    logic np_consumed = 0, an_enable, an_restart, link_speed, link_duplex;
    logic np_able, lp_np_able, next_page_loaded;
    logic [15:0] m_adv, m_np, m_lp, m_ctl, d, w;
    logic e_lpable, e_page, e_lpnp, e_pd, s_rf, s_done;
    int errors = 0, n_compared = 0, cycles = 0;
    always #5 clk = ~clk;
    anreg_sme_model sme (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    anreg_bank #(.TECH_ABILITY(TECH), .NUM_DET(3)) DUT (.clk(clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .restart_begun(restart_begun),
        .an_success(an_success), .link_ok(link_ok), .res_speed(res_speed),
        .res_duplex(res_duplex), .lp_word_valid(lp_word_valid), .lp_word_base(lp_word_base),
        .lp_word(lp_word), .lp_an_detect(lp_an_detect), .wait_timer_done(wait_timer_done),
        .det_ready(det_ready), .np_consumed(np_consumed), .an_enable(an_enable),
        .an_restart(an_restart), .link_speed(link_speed), .link_duplex(link_duplex),
        .adv_ability(adv_ability), .np_tx_word(np_tx_word), .np_able(np_able),
        .lp_np_able(lp_np_able), .next_page_loaded(next_page_loaded));
    function automatic logic [15:0] sts();
        return {TECH, 5'h00, s_done & m_ctl[12], s_rf, 1'b1, link_ok, 1'b0, 1'b1};
    endfunction : sts
    function automatic logic [15:0] expn();
        return {11'h000, e_pd, e_lpnp, 1'b1, e_page, e_lpable};
    endfunction : expn
    task automatic test_done();
        $display("compared %0d, errors %0d, late answers %0d", n_compared, errors, sme.n_late);
        if (errors == 0 && sme.n_late == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    task automatic rdc(input logic [4:0] a, input logic [15:0] exp, input string msg);
        sme.rd(a, d);
        chk(d, exp, msg);
        if (a == anreg_pkg::OFS_EXPAND) {e_page, e_pd} = 2'b00;
        if (a == anreg_pkg::OFS_STATUS) s_rf = 1'b0;
    endtask : rdc
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask : pulse
    task automatic lp_page(input logic [15:0] pw, input logic base);
        @(negedge clk);
        {lp_word, lp_word_base, lp_word_valid} = {pw, base, 1'b1};
        @(negedge clk);
        {lp_word, lp_word_valid} = {~pw, 1'b0};
        m_lp = pw;
        e_page = 1'b1;
        if (base) {e_lpnp, s_rf} = {pw[15], s_rf | pw[13]};
    endtask : lp_page
    task automatic reset_model();
        {m_adv, m_np, m_lp, m_ctl} = {6'h00, TECH, 5'h01, 16'h2001, 16'h0000, 16'h3000};
        {e_lpable, e_page, e_lpnp, e_pd, s_rf, s_done} = 6'h00;
    endtask : reset_model
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            test_done();
        end
    end
    initial begin
        void'($urandom(32'h8bb6));
        reset_model();
        repeat (3) @(posedge clk);
        @(negedge clk) arst_n = 1'b1;
        link_ok = 1'($urandom());
        chk(adv_ability, m_adv, "adv port");
        chk(np_tx_word, anreg_pkg::NP_TX_RESET, "np port");
        chk(16'({np_able, next_page_loaded, an_enable}), 16'h0005, "flags");
        rdc(anreg_pkg::OFS_CONTROL, m_ctl, "ctl reset");
        rdc(anreg_pkg::OFS_STATUS, sts(), "sts reset");
        rdc(anreg_pkg::OFS_ADVERT, m_adv, "adv reset");
        rdc(anreg_pkg::OFS_PARTNER, m_lp, "lp reset");
        rdc(anreg_pkg::OFS_EXPAND, expn(), "exp reset");
        rdc(anreg_pkg::OFS_NP_TX, m_np, "np reset");
        for (int a = 2; a < 32; a += 7) begin
            sme.wr(5'(a), 16'($urandom()));
            rdc(5'(a), 16'h0000, "unmapped");
        end
        sme.wr(anreg_pkg::OFS_PARTNER, 16'($urandom()));
        sme.wr(anreg_pkg::OFS_EXPAND, 16'hFFFF);
        rdc(anreg_pkg::OFS_PARTNER, m_lp, "lp write");
        rdc(anreg_pkg::OFS_EXPAND, expn(), "exp write");
        w = 16'($urandom()) | 16'h4000;
        sme.wr(anreg_pkg::OFS_ADVERT, w);
        m_adv = w & 16'hBFFF;
        rdc(anreg_pkg::OFS_ADVERT, m_adv, "adv rw");
        chk(adv_ability, m_adv, "adv port rw");
        lp_page(16'($urandom()) | 16'hA000, 1'b1);
        chk(16'(lp_np_able), 16'h0001, "lp np port");
        rdc(anreg_pkg::OFS_PARTNER, m_lp, "lp base");
        rdc(anreg_pkg::OFS_STATUS, sts(), "rf set");
        rdc(anreg_pkg::OFS_STATUS, sts(), "rf cleared");
        rdc(anreg_pkg::OFS_EXPAND, expn(), "page rx");
        rdc(anreg_pkg::OFS_EXPAND, expn(), "page cleared");
        lp_page(16'($urandom()) & 16'h5FFF, 1'b0);
        rdc(anreg_pkg::OFS_PARTNER, m_lp, "lp next page");
        pulse(lp_an_detect);
        e_lpable = 1'b1;
        for (int n = 0; n < 8; n++) begin
            det_ready = 3'(n);
            pulse(wait_timer_done);
            e_pd = ($countones(n) != 1);
            rdc(anreg_pkg::OFS_EXPAND, expn(), "pd fault");
        end
        fork
            sme.rd(anreg_pkg::OFS_EXPAND, d);
            lp_page(16'($urandom()), 1'b0);
        join
        chk(d, 16'h000D, "read before same cycle event");
        rdc(anreg_pkg::OFS_EXPAND, expn(), "same cycle");
        m_ctl = 16'h1200;
        sme.wr(anreg_pkg::OFS_CONTROL, m_ctl);
        rdc(anreg_pkg::OFS_CONTROL, m_ctl, "restart held");
        chk(16'(an_restart), 16'h0001, "restart port");
        sme.wr(anreg_pkg::OFS_CONTROL, 16'h1000);
        rdc(anreg_pkg::OFS_CONTROL, m_ctl, "zero no effect");
        pulse(restart_begun);
        {m_ctl[9], e_lpable} = 2'b00;
        rdc(anreg_pkg::OFS_CONTROL, m_ctl, "restart self clear");
        rdc(anreg_pkg::OFS_EXPAND, expn(), "lp able cleared");
        pulse(an_success);
        s_done = 1'b1;
        rdc(anreg_pkg::OFS_STATUS, sts(), "done");
        // speed result differs from the manual bit, so the override is visible
        {res_speed, res_duplex} = 2'($urandom()) | 2'b10;
        repeat (2) @(negedge clk);
        chk(16'({link_speed, link_duplex}), 16'({res_speed, res_duplex}), "auto cfg");
        m_ctl = 16'h0100;
        sme.wr(anreg_pkg::OFS_CONTROL, m_ctl);
        pulse(an_success);
        rdc(anreg_pkg::OFS_STATUS, sts(), "done disabled");
        chk(16'({an_enable, link_speed, link_duplex}), 16'h0001, "manual cfg");
        w = 16'($urandom());
        sme.wr(anreg_pkg::OFS_NP_TX, w);
        chk(np_tx_word, w, "np port");
        chk(16'(next_page_loaded), 16'h0001, "np loaded");
        rdc(anreg_pkg::OFS_NP_TX, w, "np rw");
        pulse(np_consumed);
        chk(16'(next_page_loaded), 16'h0000, "np consumed");
        @(negedge clk) arst_n = 1'b0;
        @(negedge clk) arst_n = 1'b1;
        reset_model();
        chk(np_tx_word, m_np, "np second reset");
        rdc(anreg_pkg::OFS_ADVERT, m_adv, "adv second reset");
        test_done();
    end
endmodule : anreg_bank_tb
